// ===== diskette_adapter_interface_bench.sv
// self-checking bench of the adapter glue, host and drive sides
// assumes the dma host model beside it; strobes driven on rising edges
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module diskette_adapter_interface_bench;
   import fda_pkg::*;
   logic clk_sys_i = 0, reset_i = 1, aen_n = 1, iow_n = 1, ior_n = 1, cdrq = 0, cint = 0;
   logic go = 0, last = 0, rst_q = 1, tc_q = 0, dack_n, dma_iow_n, tc, data_oe, drq, irq;
   logic [9:0] addr = 10'h000;
   logic [7:0] hdata = 8'h00, crdata = 8'h00, dbyte = 8'h00, rnd = 8'h19, ctrl_m = 8'h00;
   logic [7:0] dma_data, rdata, exp_v;
   logic [3:0] dly = 4'h0, cline = 4'h0, cline_q = 4'h0;
   logic [7:0] rd_q[$], wr_q[$];
   logic [9:0] miss_a[4] = '{10'h1f2, 10'h3f3, 10'h3f6, 10'h3f0};
   logic crd, ca0;
   fda_core_req_t creq;
   fda_core_drv_t cdrv;
   fda_drv_out_t dout;
   fda_drv_in_t din = 4'hf, din_q = 4'hf;
   int failures = 0, checks_done = 0, cycles = 0, n;
   always #10 clk_sys_i = ~clk_sys_i;
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr
   fda_adapter #(.NUM_DRIVES(2)) fda_adapter_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .addr_i(addr), .data_i(dma_iow_n ? hdata : dma_data), .data_o(rdata), .data_oe_o(data_oe),
      .address_enable_line_n_i(aen_n), .io_write_strobe_n_i(iow_n & dma_iow_n),
      .io_read_strobe_n_i(ior_n), .dma_acknowledge_ch_n_i(dack_n), .terminal_count_i(tc),
      .dma_request_ch_o(drq), .completion_interrupt_o(irq), .core_req_o(creq),
      .core_rd_o(crd), .core_a0_o(ca0), .core_rdata_i(crdata), .core_drq_i(cdrq),
      .core_int_i(cint),
      .core_step_i(cline[3]), .core_dir_i(cline[2]), .core_wdata_i(cline[1]),
      .core_wgate_i(cline[0]), .core_drv_o(cdrv), .drv_o(dout), .drv_i(din));
   fda_dma_host fda_dma_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .go_i(go),
      .last_i(last), .delay_i(dly), .byte_i(dbyte), .dma_request_ch_i(drq), .dack_n_o(dack_n),
      .iow_n_o(dma_iow_n), .tc_o(tc), .data_o(dma_data));
   task automatic complete_run();
      if (failures == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // result watcher: every driven read byte and every core write takes the oldest note
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         complete_run();
      end
      if (data_oe === 1'b1) begin
         exp_v = (rd_q.size() > 0) ? rd_q.pop_front() : ~rdata;
         `CHK("read data", exp_v, rdata)
      end
      if (creq.wr === 1'b1) begin
         exp_v = (wr_q.size() > 0) ? wr_q.pop_front() : ~creq.wdata;
         `CHK("core write", exp_v, creq.wdata)
      end
      if (!reset_i && !rst_q) begin
         `CHK("terminal count", tc_q, creq.tc)
         `CHK("drive lines", ~cline_q, {dout.step_n, dout.dir_n, dout.wdata_n, dout.wgate_n})
         `CHK("drive status", ~din_q, cdrv)
         if (!dack_n) `CHK("request under ack", 1'b0, drq)
      end
      rst_q <= reset_i;
      tc_q <= !dack_n & tc;
      cline_q <= cline;
      din_q <= din;
      rnd <= lfsr(rnd);
      // random lines stand in for the core's stepping and a selected drive's pulses
      cline <= rnd[3:0];
      din <= rnd[7:4];
   end
   task automatic idle(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask : idle
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic en);
      if (en && a == ADDR_DRV_CTRL) ctrl_m = d;
      if (en && a == ADDR_CORE_DATA) wr_q.push_back(d);
      @(posedge clk_sys_i);
      addr <= a;
      hdata <= d;
      aen_n <= en;
      iow_n <= 1'b0;
      @(posedge clk_sys_i);
      iow_n <= 1'b1;
      aen_n <= 1'b1;
      idle(3);
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic en, input logic [7:0] e);
      if (en && (a == ADDR_DRV_CTRL || a == ADDR_CORE_STATUS || a == ADDR_CORE_DATA))
         rd_q.push_back(e);
      @(posedge clk_sys_i);
      addr <= a;
      aen_n <= en;
      ior_n <= 1'b0;
      @(posedge clk_sys_i);
      `CHK("core read", en && (a == ADDR_CORE_STATUS || a == ADDR_CORE_DATA), crd)
      `CHK("data select", en && a == ADDR_CORE_DATA, ca0)
      ior_n <= 1'b1;
      aen_n <= 1'b1;
   endtask : rd
   task automatic chk_drive();
      `CHK("motor", ~ctrl_m[5:4], dout.motor_n)
      `CHK("select", 2'(~(2'b01 << ctrl_m[1:0])), dout.select_n)
      `CHK("core reset", ~ctrl_m[2], creq.rst)
      `CHK("interrupt", ctrl_m[3] & cint, irq)
   endtask : chk_drive
   initial begin
      idle(16);
      `CHK("lines in reset", 8'hff, dout)
      reset_i <= 1'b0;
      idle(3);
      chk_drive();
      rd(ADDR_DRV_CTRL, 1'b1, CTRL_RESET);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_DRV_CTRL, rnd | (8'h10 << rnd[1:0]), 1'b1);
         chk_drive();
         rd(ADDR_DRV_CTRL, 1'b1, ctrl_m);
      end
      wr(ADDR_DRV_CTRL, ~ctrl_m, 1'b0);
      wr(ADDR_CORE_STATUS, ~ctrl_m, 1'b1);
      rd(ADDR_DRV_CTRL, 1'b1, ctrl_m);
      foreach (miss_a[j]) rd(miss_a[j], 1'b1, 8'h00);
      rd(ADDR_DRV_CTRL, 1'b0, 8'h00);
      crdata <= 8'h3c;
      rd(ADDR_CORE_STATUS, 1'b1, 8'h3c);
      crdata <= 8'hc3;
      rd(ADDR_CORE_DATA, 1'b1, 8'hc3);
      wr(ADDR_CORE_DATA, 8'ha5, 1'b1);
      wr(ADDR_CORE_DATA, GAP_LENGTH_PARAMETER, 1'b1);
      wr(ADDR_CORE_DATA, HEAD_LOAD_PARAMETER, 1'b1);
      cint <= 1'b1;
      wr(ADDR_DRV_CTRL, 8'h1c, 1'b1);
      chk_drive();
      // software waits last milliseconds; the bench keeps their place, not their length
      idle(2);
      cdrq <= 1'b1;
      idle(1);
      `CHK("dma request", 1'b1, drq)
      rd(ADDR_CORE_DATA, 1'b1, 8'hc3);
      idle(1);
      `CHK("request after data read", 1'b0, drq)
      cdrq <= 1'b0;
      idle(1);
      cdrq <= 1'b1;
      idle(2);
      `CHK("request again", 1'b1, drq)
      for (int k = 0; k < 2; k++) begin
         dbyte <= rnd;
         wr_q.push_back(rnd);
         last <= k[0];
         dly <= 4'(k * 5);
         go <= 1'b1;
         n = 0;
         while (dack_n !== 1'b0 && n < 50) begin
            @(posedge clk_sys_i);
            n++;
         end
         cdrq <= (k == 0);
         go <= 1'b0;
         if (n == 50) failures++;
         idle(4);
      end
      wr(ADDR_DRV_CTRL, 8'hf7, 1'b1);
      reset_i <= 1'b1;
      idle(2);
      reset_i <= 1'b0;
      ctrl_m = 8'h00;
      idle(3);
      chk_drive();
      rd(ADDR_DRV_CTRL, 1'b1, CTRL_RESET);
      idle(4);
      complete_run();
   end
endmodule : diskette_adapter_interface_bench
`default_nettype wire

// ===== fda_adapter.sv
// diskette adapter glue: host channel decode, dma and interrupt gating,
// drive output control register and drive-side line conditioning
// assumes host strobes are synchronous to clk_sys_i and the core answers reads combinationally
//
// Behaviour
// - ten address bits select the register moved on the eight-bit data bus
// - with address enable asserted, address lines are ignored entirely
// - writes are captured at the trailing rising edge of the write strobe
// - selected register drives data bus one cycle behind the active read strobe
// - dma acknowledge forces the core data register and withdraws dma request
// - terminal count with acknowledge is registered and passed to the core
// - reset aborts operation and clears the drive output control register
// - dma request drops on acknowledge or a read of the data register
// - completion interrupt raised on core completion while request enable is set, cleared by reading results
// - control register holds select code, core reset, request enable, four motors
`timescale 1ns/1ns
`default_nettype none
module fda_adapter #(
   parameter int NUM_DRIVES = 2
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [fda_pkg::ADDR_W-1:0] addr_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   input wire logic address_enable_line_n_i,
   input wire logic io_write_strobe_n_i,
   input wire logic io_read_strobe_n_i,
   input wire logic dma_acknowledge_ch_n_i,
   input wire logic terminal_count_i,
   output logic dma_request_ch_o,
   output logic completion_interrupt_o,
   output fda_pkg::fda_core_req_t core_req_o,
   output logic core_rd_o,
   output logic core_a0_o,
   input wire logic [7:0] core_rdata_i,
   input wire logic core_drq_i,
   input wire logic core_int_i,
   input wire logic core_step_i,
   input wire logic core_dir_i,
   input wire logic core_wdata_i,
   input wire logic core_wgate_i,
   output fda_pkg::fda_core_drv_t core_drv_o,
   output fda_pkg::fda_drv_out_t drv_o,
   input wire fda_pkg::fda_drv_in_t drv_i
);
   import fda_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl;
      fda_sel_t wr_sel;
      logic [7:0] wr_data;
      logic iow_n_d;
      logic [7:0] rd_data;
      logic rd_oe;
      logic drq_block;
      fda_core_req_t req;
      fda_drv_out_t drv;
      fda_core_drv_t din;
   } fda_state_t;

   fda_state_t state_ff;
   fda_state_t nxt_state;
   fda_sel_t sel;
   fda_sel_t rd_sel;
   logic wr_edge;
   logic req_en;
   logic [CTRL_SEL_W-1:0] drv_sel;
   logic [CTRL_MOTOR_W-1:0] motor_en;

   assign req_en = state_ff.ctrl[CTRL_EN_BIT];
   assign drv_sel = state_ff.ctrl[CTRL_SEL_LSB +: CTRL_SEL_W];
   assign motor_en = state_ff.ctrl[CTRL_MOTOR_LSB +: CTRL_MOTOR_W];

   // acknowledge overrides any address; address enable blanks the decode
   always_comb begin
      if (!dma_acknowledge_ch_n_i) begin
         sel = FDA_SEL_DATA;
      end else if (!address_enable_line_n_i) begin
         sel = FDA_SEL_NONE;
      end else if (addr_i == ADDR_DRV_CTRL) begin
         sel = FDA_SEL_CTRL;
      end else if (addr_i == ADDR_CORE_STATUS) begin
         sel = FDA_SEL_STATUS;
      end else if (addr_i == ADDR_CORE_DATA) begin
         sel = FDA_SEL_DATA;
      end else begin
         sel = FDA_SEL_NONE;
      end
   end

   assign rd_sel = io_read_strobe_n_i ? FDA_SEL_NONE : sel;
   assign wr_edge = !state_ff.iow_n_d && io_write_strobe_n_i;
   assign core_rd_o = (rd_sel == FDA_SEL_STATUS) || (rd_sel == FDA_SEL_DATA);
   assign core_a0_o = (sel == FDA_SEL_DATA);

   always_comb begin
      nxt_state = state_ff;
      nxt_state.iow_n_d = io_write_strobe_n_i;
      nxt_state.req.wr = 1'b0;
      // the address may already be gone at the trailing edge, so the target
      // and data are held from the last cycle the strobe was low
      if (!io_write_strobe_n_i) begin
         nxt_state.wr_sel = sel;
         nxt_state.wr_data = data_i;
      end
      if (wr_edge) begin
         case (state_ff.wr_sel)
            FDA_SEL_CTRL: begin
               nxt_state.ctrl = state_ff.wr_data;
            end
            FDA_SEL_DATA: begin
               nxt_state.req.wr = 1'b1;
               nxt_state.req.wdata = state_ff.wr_data;
            end
            default: begin
               // status register is read-only; other addresses are not ours
            end
         endcase
      end
      // data bus is driven from flops, one cycle behind the strobe
      nxt_state.rd_oe = (rd_sel != FDA_SEL_NONE);
      case (rd_sel)
         FDA_SEL_CTRL: nxt_state.rd_data = state_ff.ctrl;
         FDA_SEL_STATUS: nxt_state.rd_data = core_rdata_i;
         FDA_SEL_DATA: nxt_state.rd_data = core_rdata_i;
         default: nxt_state.rd_data = state_ff.rd_data;
      endcase
      // a programmed read of the data byte retires the pending request; the
      // block lasts until the core drops its own request, set winning clear
      if ((rd_sel == FDA_SEL_DATA) && dma_acknowledge_ch_n_i) begin
         nxt_state.drq_block = 1'b1;
      end else if (!core_drq_i) begin
         nxt_state.drq_block = 1'b0;
      end
      nxt_state.req.tc = terminal_count_i && !dma_acknowledge_ch_n_i;
      nxt_state.req.rst = !state_ff.ctrl[CTRL_NRST_BIT];
      nxt_state.drv.step_n = !core_step_i;
      nxt_state.drv.dir_n = !core_dir_i;
      nxt_state.drv.wdata_n = !core_wdata_i;
      nxt_state.drv.wgate_n = !core_wgate_i;
      nxt_state.din.index = !drv_i.index_n;
      nxt_state.din.track0 = !drv_i.track0_n;
      nxt_state.din.wprot = !drv_i.wprot_n;
      nxt_state.din.rdata = !drv_i.rdata_n;
      if (reset_i) begin
         nxt_state = '0;
         nxt_state.ctrl = CTRL_RESET;
         nxt_state.iow_n_d = 1'b1;
         nxt_state.req.rst = 1'b1;
         nxt_state.drv = '1;
      end
   end

   logic [NUM_DRIVES-1:0] nxt_drv_sel_n;
   logic [NUM_DRIVES-1:0] nxt_drv_motor_n;
   logic [NUM_DRIVES-1:0] drv_sel_n_ff;
   logic [NUM_DRIVES-1:0] drv_motor_n_ff;

   // per-drive select decode and motor lines; select follows the code alone,
   // keeping the motor-before-select order is left to software
   for (genvar i = 0; i < NUM_DRIVES; i++) begin : g_drive
      assign nxt_drv_sel_n[i] = reset_i ? 1'b1 : (drv_sel != CTRL_SEL_W'(i));
      assign nxt_drv_motor_n[i] = reset_i ? 1'b1 : !motor_en[i];
   end

   always_ff @(posedge clk_sys_i) begin
      state_ff <= nxt_state;
      drv_sel_n_ff <= nxt_drv_sel_n;
      drv_motor_n_ff <= nxt_drv_motor_n;
   end

   always_comb begin
      drv_o = state_ff.drv;
      drv_o.select_n = drv_sel_n_ff[1:0];
      drv_o.motor_n = drv_motor_n_ff[1:0];
   end

   assign data_o = state_ff.rd_data;
   assign data_oe_o = state_ff.rd_oe;
   // requests reach the channel only when enabled in the control register
   assign dma_request_ch_o = core_drq_i && req_en && dma_acknowledge_ch_n_i
      && !state_ff.drq_block;
   assign completion_interrupt_o = core_int_i && req_en;
   assign core_req_o = state_ff.req;
   assign core_drv_o = state_ff.din;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   // reset is checked while it is high, so the default disable is switched off here
   property p_reset_clears;
      @(posedge clk_sys_i) disable iff (1'b0) reset_i |=> (state_ff.ctrl == 8'h00) && core_req_o.rst
         && (drv_o.motor_n == 2'b11);
   endproperty

   AST_CTRL_WRITE: assert property (
      (!io_write_strobe_n_i && sel == FDA_SEL_CTRL) ##1 io_write_strobe_n_i
      |=> state_ff.ctrl == $past(state_ff.wr_data))
      else $error("control register missed trailing-edge write");
   AST_RESET_CLEARS: assert property (p_reset_clears)
      else $error("reset did not clear control state");
   AST_AEN_IGNORE: assert property (
      (!address_enable_line_n_i && dma_acknowledge_ch_n_i) |-> !core_rd_o && sel == FDA_SEL_NONE)
      else $error("decode answered while address enable asserted");
   AST_READ_DRIVE: assert property (
      (!io_read_strobe_n_i && address_enable_line_n_i && dma_acknowledge_ch_n_i
       && addr_i == ADDR_DRV_CTRL) |=> data_oe_o && data_o == $past(state_ff.ctrl))
      else $error("control register not driven during read");
   AST_DACK_DRQ: assert property (!dma_acknowledge_ch_n_i |-> !dma_request_ch_o)
      else $error("dma request held during acknowledge");
   AST_DRQ_READ: assert property (
      (core_rd_o && core_a0_o && dma_acknowledge_ch_n_i) ##1 core_drq_i
      |-> !dma_request_ch_o)
      else $error("dma request survived data read");
   AST_TC_PASS: assert property (
      (terminal_count_i && !dma_acknowledge_ch_n_i) |=> core_req_o.tc)
      else $error("terminal count not passed");
   AST_IRQ_GATE: assert property (
      (core_int_i && !req_en) |-> !completion_interrupt_o)
      else $error("interrupt escaped while disabled");
   AST_SELECT_DECODE: assert property (
      (state_ff.ctrl[1:0] == 2'b01) [*2] |-> drv_o.select_n == 2'b01)
      else $error("drive select decode wrong");
   AST_MOTOR_LOW: assert property (
      state_ff.ctrl[CTRL_MOTOR_LSB] |=> !drv_o.motor_n[0])
      else $error("motor line not driven low");
   AST_DACK_WRITE: assert property (
      (!io_write_strobe_n_i && !dma_acknowledge_ch_n_i) ##1 io_write_strobe_n_i
      |=> core_req_o.wr)
      else $error("acknowledged write not sent to data register");

   // remaining read, write, dma and drive-line paths
   AST_READ_STATUS: assert property (
      (!io_read_strobe_n_i && address_enable_line_n_i && dma_acknowledge_ch_n_i
       && addr_i == ADDR_CORE_STATUS) |=> data_oe_o && data_o == $past(core_rdata_i))
      else $error("status byte not driven during read");
   AST_OE_IDLE: assert property (io_read_strobe_n_i |=> !data_oe_o)
      else $error("data bus driven without read strobe");
   AST_READ_HOLD: assert property (io_read_strobe_n_i |=> $stable(data_o))
      else $error("read data changed without a read");
   // status is read-only: a write there must leave everything alone
   AST_STATUS_RO: assert property (
      (!io_write_strobe_n_i && sel == FDA_SEL_STATUS) ##1 io_write_strobe_n_i
      |=> $stable(state_ff.ctrl) && !core_req_o.wr)
      else $error("write to status register had an effect");
   AST_CORE_WRITE_DATA: assert property (
      (!io_write_strobe_n_i && sel == FDA_SEL_DATA) ##1 io_write_strobe_n_i
      |=> core_req_o.wr && core_req_o.wdata == $past(data_i, 2))
      else $error("data register write carried the wrong byte");
   AST_WR_PULSE: assert property (core_req_o.wr |=> !core_req_o.wr)
      else $error("core write strobe longer than one cycle");
   AST_DACK_SELECT: assert property (!dma_acknowledge_ch_n_i |-> core_a0_o)
      else $error("acknowledge did not select the data register");
   AST_TC_NEED_ACK: assert property (dma_acknowledge_ch_n_i |=> !core_req_o.tc)
      else $error("terminal count passed without acknowledge");
   // the default disable would hide this check, so it is switched off
   AST_RESET_DRIVE: assert property (
      @(posedge clk_sys_i) disable iff (1'b0)
      reset_i |=> (drv_o == '1) && !data_oe_o && !core_req_o.wr && !core_req_o.tc)
      else $error("reset left a line active");
   AST_DRQ_ENABLE: assert property (!req_en |-> !dma_request_ch_o)
      else $error("dma request escaped while disabled");
   // a low core request one cycle earlier has cleared any read block
   AST_DRQ_RAISE: assert property (
      (!core_drq_i && io_read_strobe_n_i) ##1 (core_drq_i && req_en && dma_acknowledge_ch_n_i)
      |-> dma_request_ch_o)
      else $error("ready byte raised no dma request");
   AST_RST_BIT: assert property (!state_ff.ctrl[CTRL_NRST_BIT] |=> core_req_o.rst)
      else $error("core reset not asserted from control register");
   AST_DESELECT: assert property (
      (state_ff.ctrl[1:0] == 2'b11) |=> drv_o.select_n == 2'b11)
      else $error("a drive stayed selected for an absent unit");
   AST_MOTOR_B: assert property (
      state_ff.ctrl[CTRL_MOTOR_LSB + 1] |=> !drv_o.motor_n[1])
      else $error("second motor line not driven low");
   AST_STEP_LOW: assert property (core_step_i |=> !drv_o.step_n)
      else $error("step line not driven low");
   AST_WGATE_OFF: assert property (!core_wgate_i |=> drv_o.wgate_n)
      else $error("write enable line active without core gate");
   AST_INDEX_IN: assert property (!drv_i.index_n |=> core_drv_o.index)
      else $error("index pulse not passed to the core");
   AST_TRACK0_IN: assert property (!drv_i.track0_n |=> core_drv_o.track0)
      else $error("track zero not passed to the core");

   COV_CTRL_WRITE: cover property (wr_edge && state_ff.wr_sel == FDA_SEL_CTRL);
   COV_DMA_XFER: cover property (dma_request_ch_o ##[1:20] !dma_acknowledge_ch_n_i);
   COV_TC: cover property (core_req_o.tc ##[1:20] completion_interrupt_o);
   COV_DATA_READ: cover property (core_rd_o && core_a0_o && dma_acknowledge_ch_n_i);
   COV_STATUS_READ: cover property (core_rd_o && !core_a0_o);
endmodule : fda_adapter
`default_nettype wire

// ===== fda_dma_host.sv
// host-side dma controller model: answers the adapter's dma request
// assumes one clock; prompt or slow answer chosen by delay_i
`timescale 1ns/1ns
`default_nettype none
module fda_dma_host (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic go_i,
   input wire logic last_i,
   input wire logic [3:0] delay_i,
   input wire logic [7:0] byte_i,
   input wire logic dma_request_ch_i,
   output logic dack_n_o,
   output logic iow_n_o,
   output logic tc_o,
   output logic [7:0] data_o
);
   logic [3:0] wait_ff;
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         dack_n_o <= 1'b1;
         iow_n_o <= 1'b1;
         tc_o <= 1'b0;
         data_o <= 8'h00;
         wait_ff <= 4'h0;
      end else if (!dack_n_o) begin
         // released bus shows the inverse, not a stale byte
         dack_n_o <= 1'b1;
         iow_n_o <= 1'b1;
         tc_o <= 1'b0;
         data_o <= ~data_o;
      end else if (go_i && dma_request_ch_i) begin
         if (wait_ff == delay_i) begin
            dack_n_o <= 1'b0;
            iow_n_o <= 1'b0;
            tc_o <= last_i;
            data_o <= byte_i;
            wait_ff <= 4'h0;
         end else begin
            wait_ff <= wait_ff + 4'h1;
         end
      end else begin
         wait_ff <= 4'h0;
      end
   end
endmodule : fda_dma_host
`default_nettype wire

// ===== fda_pkg.sv
// constants, field layouts and carrier types of the diskette adapter glue logic
// assumes one synchronous clock domain; host channel pins arrive already synchronous
package fda_pkg;
   // host register byte addresses on the ten-bit channel address
   localparam int ADDR_W = 10;
   localparam logic [9:0] ADDR_DRV_CTRL = 10'h3f2;
   localparam logic [9:0] ADDR_CORE_STATUS = 10'h3f4;
   localparam logic [9:0] ADDR_CORE_DATA = 10'h3f5;

   // drive_output_control_register layout
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_SEL_W = 2;
   localparam int CTRL_NRST_BIT = 2;
   localparam int CTRL_EN_BIT = 3;
   localparam int CTRL_MOTOR_LSB = 4;
   localparam int CTRL_MOTOR_W = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // values host software programs into the floppy_controller_core
   localparam logic [7:0] GAP_LENGTH_PARAMETER = 8'h2a;
   localparam logic [7:0] HEAD_LOAD_PARAMETER = 8'h01;
   localparam int STEP_RATE_MS = 8;
   localparam int HEAD_ENGAGE_DELAY_MS = 35;
   localparam int HEAD_SETTLE_DELAY_MS = 25;
   localparam int MOTOR_START_MS = 500;

   // which register a host access reaches
   typedef enum logic [1:0] {
      FDA_SEL_NONE = 2'b00,
      FDA_SEL_CTRL = 2'b01,
      FDA_SEL_STATUS = 2'b10,
      FDA_SEL_DATA = 2'b11
   } fda_sel_t;

   // lines toward the attached_drive, all active low
   typedef struct packed {
      logic [1:0] select_n;
      logic [1:0] motor_n;
      logic step_n;
      logic dir_n;
      logic wdata_n;
      logic wgate_n;
   } fda_drv_out_t;

   // lines from the attached_drive, all active low
   typedef struct packed {
      logic index_n;
      logic track0_n;
      logic wprot_n;
      logic rdata_n;
   } fda_drv_in_t;

   // drive status toward the core, active high
   typedef struct packed {
      logic index;
      logic track0;
      logic wprot;
      logic rdata;
   } fda_core_drv_t;

   // write and control requests toward the core
   typedef struct packed {
      logic wr;
      logic [7:0] wdata;
      logic tc;
      logic rst;
   } fda_core_req_t;
endpackage : fda_pkg
